// ### src/smsp_pkg.sv
// shared constants, register map and types for the spi master/slave port
package smsp_pkg;
    // ------------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------------
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam int          NUM_SS        = 4;
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_DIV       = 8'h04;
    localparam logic [7:0]  REG_DELAY     = 8'h08;
    localparam logic [7:0]  REG_GAP       = 8'h0C;
    localparam logic [7:0]  REG_MTX       = 8'h10;
    localparam logic [7:0]  REG_MRX       = 8'h14;
    localparam logic [7:0]  REG_CMD       = 8'h18;
    localparam logic [7:0]  REG_STATUS    = 8'h1C;
    localparam logic [7:0]  REG_STX       = 8'h20;
    localparam logic [7:0]  REG_SRX       = 8'h24;

    // ------------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] ss_sel;     // which select line the master drives
        logic       mosi_en;    // mosi pin connected
        logic       miso_en;    // miso pin connected
        logic       fast;       // divider-only fast master mode
        logic       w32;        // 1: 32-bit words, 0: 8-bit words
        logic       cpol;
        logic       cpha;
    } smsp_ctrl_t;

    localparam logic [7:0]  CTRL_RST      = 8'h30;
    localparam int          CMD_START_BIT = 0;
    localparam int          ST_W          = 7;
    localparam int          ST_M_BUSY     = 0;
    localparam int          ST_M_DONE     = 1;
    localparam int          ST_M_REFUSED  = 2;
    localparam int          ST_S_REQ      = 3;
    localparam int          ST_S_END      = 4;
    localparam int          ST_S_RXVALID  = 5;
    localparam int          ST_S_ACTIVE   = 6;
    localparam int          CNT_W         = 16;
    localparam logic [15:0] DIV_RST       = 16'h0004;
    localparam logic [15:0] SLOW_MIN_DIV  = 16'h0002;
    localparam logic [15:0] DELAY_RST     = 16'h0002;
    localparam logic [15:0] GAP_RST       = 16'h0004;
    localparam logic [5:0]  BITS_8        = 6'h08;
    localparam logic [5:0]  BITS_32       = 6'h20;

    // serial pin inputs, synchronised as one group
    typedef struct packed {
        logic m_miso;
        logic s_sclk;
        logic s_ss;
        logic s_mosi;
    } smsp_pins_t;

    typedef enum logic [1:0] { M_IDLE, M_SETUP, M_SHIFT } smsp_mstate_t;
endpackage : smsp_pkg

// ### src/smsp_port.sv
// spi master and slave port with a plain register port
//------------------------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------------------------
// Summary of operation
// - master asserts select before clocks, drops after
// - both ends shift data while select asserted
// - slave select active high; ignore lines when low
// - cpol0 cpha1: launch rising, sample falling
// - cpol0 cpha0: preset bit, sample rising edges
// - cpol1 cpha0: preset bit, sample falling edges
// - cpol1 cpha1: launch falling, sample rising
// - programmable delay from select to first data
// - programmable minimum select deassert gap
// - fast mode: serial clock from programmable divider
// - master works with mosi or miso absent
// - fast mode refused without miso
// - one select per slave, at most one asserted
// - slave requests transmit data on select assertion
// - slave reports transaction end on deassertion
// - slave word width 8 or 32 bits
// - early start stalls until gap has elapsed
// - slave always needs its mosi input
//
// Design decisions made here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module smsp_port
    import smsp_pkg::*;
(
    input  wire logic              clk_sys_i,    // 20 MHz system clock
    input  wire logic              srst_i,       // synchronous reset, active high
    input  wire logic [ADDR_W-1:0] addr_i,       // register byte address
    input  wire logic [DATA_W-1:0] wdata_i,      // write data
    input  wire logic              wr_i,         // write strobe
    input  wire logic              rd_i,         // read strobe
    output logic      [DATA_W-1:0] rdata_o,      // read data, cycle after rd_i
    output logic                   m_sclk_o,     // master serial clock
    output logic                   m_mosi_o,     // master data out
    output logic                   m_mosi_oe_o,  // master data out enable
    input  wire logic              m_miso_i,     // master data in (async)
    output logic      [NUM_SS-1:0] m_ss_o,       // master selects, active high
    input  wire logic              s_sclk_i,     // slave serial clock (async)
    input  wire logic              s_ss_i,       // slave select (async)
    input  wire logic              s_mosi_i,     // slave data in (async)
    output logic                   s_miso_o,     // slave data out
    output logic                   s_miso_oe_o,  // slave data out enable
    output logic                   slv_req_o,    // pulse: client must supply tx data
    output logic                   slv_end_o     // pulse: transaction ended
);
    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [5:0] word_bits(input logic w32);
        return w32 ? BITS_32 : BITS_8;
    endfunction : word_bits

    // msb of the active word always sits at bit 31
    function automatic logic [31:0] align_word(input logic [31:0] d, input logic w32);
        return w32 ? d : {d[7:0], 24'h000000};
    endfunction : align_word

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    smsp_pins_t pin_meta_r, pin_sync_r, pin_dly_r;

    always_ff @(posedge clk_sys_i) begin
        pin_meta_r <= '{m_miso: m_miso_i, s_sclk: s_sclk_i, s_ss: s_ss_i, s_mosi: s_mosi_i};
        pin_sync_r <= pin_meta_r;
        pin_dly_r  <= pin_sync_r;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    smsp_ctrl_t           cfg_r;
    logic [CNT_W-1:0]     div_r, dly_r, gap_r;
    logic [31:0]          mtx_r, mrx_r, stx_r, srx_r;
    logic [ST_W-1:0]      st_sticky_r, st_set, st_clr;
    logic                 pend_r;
    logic                 start_wr;
    smsp_mstate_t         mst_r;

    assign start_wr = wr_i && addr_i == REG_CMD && wdata_i[CMD_START_BIT];

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            cfg_r <= smsp_ctrl_t'(CTRL_RST);
            div_r <= DIV_RST;
            dly_r <= DELAY_RST;
            gap_r <= GAP_RST;
            mtx_r <= 32'h00000000;
            stx_r <= 32'h00000000;
        end else if (wr_i) begin
            if (addr_i == REG_CTRL) begin
                cfg_r <= smsp_ctrl_t'(wdata_i[7:0]);
            end else if (addr_i == REG_DIV) begin
                div_r <= wdata_i[CNT_W-1:0];
            end else if (addr_i == REG_DELAY) begin
                dly_r <= wdata_i[CNT_W-1:0];
            end else if (addr_i == REG_GAP) begin
                gap_r <= wdata_i[CNT_W-1:0];
            end else if (addr_i == REG_MTX) begin
                mtx_r <= wdata_i;
            end else if (addr_i == REG_STX) begin
                stx_r <= wdata_i;
            end
        end
    end

    // a start asked for while busy or in the gap stays pending until idle and the gap is over
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            pend_r <= 1'b0;
        end else if (start_wr && !(cfg_r.fast && !cfg_r.miso_en)) begin
            pend_r <= 1'b1;
        end else if (mst_r == M_IDLE && gap_cnt_r == '0) begin
            pend_r <= 1'b0;
        end
    end

    // sticky status: write one to clear, a hardware set in the same cycle wins
    assign st_clr = (wr_i && addr_i == REG_STATUS) ? wdata_i[ST_W-1:0] : '0;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            st_sticky_r <= '0;
        end else begin
            st_sticky_r <= (st_sticky_r & ~st_clr) | st_set;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            if (addr_i == REG_CTRL) begin
                rdata_o <= {24'h000000, cfg_r};
            end else if (addr_i == REG_DIV) begin
                rdata_o <= {16'h0000, div_r};
            end else if (addr_i == REG_DELAY) begin
                rdata_o <= {16'h0000, dly_r};
            end else if (addr_i == REG_GAP) begin
                rdata_o <= {16'h0000, gap_r};
            end else if (addr_i == REG_MTX) begin
                rdata_o <= mtx_r;
            end else if (addr_i == REG_MRX) begin
                rdata_o <= mrx_r;
            end else if (addr_i == REG_STATUS) begin
                rdata_o <= {25'h0000000, st_sticky_r};
            end else if (addr_i == REG_STX) begin
                rdata_o <= stx_r;
            end else if (addr_i == REG_SRX) begin
                rdata_o <= srx_r;
            end else begin
                rdata_o <= '0;
            end
        end
    end

    // ------------------------------------------------------------------
    // master
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] cnt_r, gap_cnt_r, half_div;
    logic [6:0]       edge_r;
    logic [31:0]      mtx_sr_r, mrx_sr_r;
    logic [6:0]       m_edges;
    logic             m_lead, m_last_edge, m_done;

    // slow mode keeps a floor on the half period; fast mode runs at the divider
    assign half_div    = (cfg_r.fast || div_r > SLOW_MIN_DIV) ? div_r : SLOW_MIN_DIV;
    assign m_edges     = {word_bits(cfg_r.w32), 1'b0};
    assign m_lead      = !edge_r[0];
    assign m_last_edge = edge_r == m_edges - 7'd1;
    assign m_done      = mst_r == M_SHIFT && cnt_r == '0 && edge_r == m_edges;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mst_r       <= M_IDLE;
            m_ss_o      <= '0;
            m_sclk_o    <= 1'b0;
            m_mosi_o    <= 1'b0;
            m_mosi_oe_o <= 1'b0;
            cnt_r       <= '0;
            gap_cnt_r   <= '0;
            edge_r      <= '0;
            mtx_sr_r    <= '0;
            mrx_sr_r    <= '0;
            mrx_r       <= '0;
        end else begin
            m_mosi_oe_o <= cfg_r.mosi_en;
            case (mst_r)
                M_IDLE: begin
                    m_sclk_o <= cfg_r.cpol;
                    if (gap_cnt_r != '0) begin
                        gap_cnt_r <= gap_cnt_r - 1'b1;
                    end else if (pend_r) begin
                        m_ss_o   <= NUM_SS'(1) << cfg_r.ss_sel;
                        mst_r    <= M_SETUP;
                        cnt_r    <= dly_r;
                        edge_r   <= '0;
                        mtx_sr_r <= align_word(mtx_r, cfg_r.w32);
                    end
                end
                M_SETUP: begin
                    if (cnt_r != '0) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else begin
                        mst_r <= M_SHIFT;
                        cnt_r <= half_div;
                        if (!cfg_r.cpha) begin
                            m_mosi_o <= mtx_sr_r[31];
                            mtx_sr_r <= mtx_sr_r << 1;
                        end
                    end
                end
                M_SHIFT: begin
                    if (m_done) begin
                        m_ss_o    <= '0;
                        mst_r     <= M_IDLE;
                        gap_cnt_r <= gap_r;
                        mrx_r     <= cfg_r.w32 ? mrx_sr_r : {24'h000000, mrx_sr_r[7:0]};
                    end else if (cnt_r != '0) begin
                        cnt_r <= cnt_r - 1'b1;
                    end else begin
                        cnt_r    <= half_div;
                        edge_r   <= edge_r + 7'd1;
                        m_sclk_o <= ~m_sclk_o;
                        // sample on leading edges for cpha 0, trailing for cpha 1
                        if (m_lead == !cfg_r.cpha) begin
                            mrx_sr_r <= {mrx_sr_r[30:0], cfg_r.miso_en & pin_sync_r.m_miso};
                        end else if (cfg_r.cpha || !m_last_edge) begin
                            m_mosi_o <= mtx_sr_r[31];
                            mtx_sr_r <= mtx_sr_r << 1;
                        end
                    end
                end
                default: begin
                    mst_r <= M_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // slave
    // ------------------------------------------------------------------
    logic        s_rise, s_fall, s_act, s_lead, s_trail;
    logic [31:0] stx_sr_r, srx_sr_r, stx_al;
    logic [5:0]  sbit_r;
    logic        s_word_done;

    assign stx_al  = align_word(stx_r, cfg_r.w32);

    assign s_rise  = pin_sync_r.s_ss && !pin_dly_r.s_ss;
    assign s_fall  = !pin_sync_r.s_ss && pin_dly_r.s_ss;
    // clock and data count only while select is high and was high before
    assign s_act   = pin_sync_r.s_ss && pin_dly_r.s_ss;
    assign s_lead  = s_act && pin_sync_r.s_sclk != pin_dly_r.s_sclk && pin_dly_r.s_sclk == cfg_r.cpol;
    assign s_trail = s_act && pin_sync_r.s_sclk != pin_dly_r.s_sclk && pin_dly_r.s_sclk != cfg_r.cpol;
    assign s_word_done = (s_lead == !cfg_r.cpha) && (s_lead || s_trail)
                         && sbit_r == word_bits(cfg_r.w32) - 6'd1;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            s_miso_o    <= 1'b0;
            s_miso_oe_o <= 1'b0;
            slv_req_o   <= 1'b0;
            slv_end_o   <= 1'b0;
            stx_sr_r    <= '0;
            srx_sr_r    <= '0;
            srx_r       <= '0;
            sbit_r      <= '0;
        end else begin
            s_miso_oe_o <= pin_sync_r.s_ss;
            slv_req_o   <= s_rise;
            slv_end_o   <= s_fall;
            if (s_rise) begin
                sbit_r <= '0;
                if (!cfg_r.cpha) begin
                    s_miso_o <= stx_al[31];
                    stx_sr_r <= stx_al << 1;
                end else begin
                    stx_sr_r <= stx_al;
                end
            end else if (s_lead || s_trail) begin
                if (s_lead == !cfg_r.cpha) begin
                    // mosi is always read: the slave has no way to run without it
                    srx_sr_r <= {srx_sr_r[30:0], pin_sync_r.s_mosi};
                    if (s_word_done) begin
                        sbit_r   <= '0;
                        srx_r    <= cfg_r.w32 ? {srx_sr_r[30:0], pin_sync_r.s_mosi}
                                              : {24'h000000, srx_sr_r[6:0], pin_sync_r.s_mosi};
                        stx_sr_r <= align_word(stx_r, cfg_r.w32);
                    end else begin
                        sbit_r <= sbit_r + 6'd1;
                    end
                end else begin
                    s_miso_o <= stx_sr_r[31];
                    stx_sr_r <= stx_sr_r << 1;
                end
            end
        end
    end

    always_comb begin
        st_set               = '0;
        st_set[ST_M_BUSY]    = mst_r != M_IDLE;
        st_set[ST_M_DONE]    = m_done;
        st_set[ST_M_REFUSED] = start_wr && cfg_r.fast && !cfg_r.miso_en;
        st_set[ST_S_REQ]     = s_rise;
        st_set[ST_S_END]     = s_fall;
        st_set[ST_S_RXVALID] = s_word_done;
        st_set[ST_S_ACTIVE]  = s_act;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    logic [CNT_W-1:0] sel_age_r, idle_age_r;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i || m_ss_o == '0) begin
            sel_age_r <= '0;
        end else if (sel_age_r != '1) begin
            sel_age_r <= sel_age_r + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            idle_age_r <= '1;
        end else if (m_ss_o != '0) begin
            idle_age_r <= '0;
        end else if (idle_age_r != '1) begin
            idle_age_r <= idle_age_r + 1'b1;
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    a_clock_under_select: assert property ($changed(m_sclk_o) && mst_r == M_SHIFT |-> m_ss_o != '0)
        else $error("serial clock moved without a select");
    a_setup_delay_held: assert property (mst_r == M_SHIFT && $changed(m_sclk_o) |-> sel_age_r > dly_r)
        else $error("first clock came before the select-to-data delay");
    a_gap_respected: assert property ($rose(m_ss_o != '0) |-> idle_age_r >= gap_r)
        else $error("select reasserted inside the deassert gap");
    a_one_select: assert property ($onehot0(m_ss_o))
        else $error("more than one select asserted");
    a_idle_clock_park: assert property (mst_r == M_IDLE ##1 mst_r == M_IDLE |-> m_sclk_o == $past(cfg_r.cpol))
        else $error("idle serial clock not at polarity level");
    a_fast_refused: assert property (start_wr && cfg_r.fast && !cfg_r.miso_en && !pend_r
                                     |=> !pend_r && st_sticky_r[ST_M_REFUSED])
        else $error("fast mode start without miso was not refused");
    a_mosi_absent: assert property (!cfg_r.mosi_en ##1 !cfg_r.mosi_en |-> !m_mosi_oe_o)
        else $error("mosi driven while marked absent");
    a_slave_request: assert property (s_rise |=> slv_req_o ##1 !slv_req_o)
        else $error("no single request pulse on select assertion");
    a_slave_end: assert property (s_fall |=> slv_end_o && !s_miso_oe_o)
        else $error("no end pulse after select deassertion");
    a_slave_quiet: assert property (!pin_sync_r.s_ss |=> !s_miso_oe_o && $stable(sbit_r))
        else $error("slave reacted while select low");

    c_master_done: cover property (m_done);
    c_start_stalled: cover property (pend_r && gap_cnt_r != '0);
    c_slave_word: cover property (s_word_done && cfg_r.w32);
    c_refused: cover property (st_set[ST_M_REFUSED]);
endmodule : smsp_port

// ### verification/smsp_far.sv
// behavioural spi slave standing on the master port
`timescale 1ns/1ps
module smsp_far (
    input  wire logic        sclk_i,  // serial clock from master
    input  wire logic        ss_i,    // any select asserted
    input  wire logic        mosi_i,  // data from master
    input  wire logic        cpol_i,  // idle clock level
    input  wire logic        cpha_i,  // clock phase
    input  wire logic [31:0] tx_i,    // word returned, msb first
    output logic             miso_o,  // data to master
    output logic      [31:0] rx_o     // bits received
);
    logic [31:0] sh_r;
    logic        first_r;
    logic        ss_q   = 1'b0;
    logic        sclk_q = 1'b0;
    // a released line shows the inverse of the last bit, so stale data never matches
    assign miso_o = ss_i ? sh_r[31] : ~sh_r[31];
    // one process owns the shift state: select rise loads, clock changes shift
    always @(ss_i or sclk_i) begin
        if (ss_i && !ss_q) begin
            sh_r    = tx_i;
            rx_o    = 32'h0;
            first_r = 1'b1;
        end else if (ss_i && sclk_i != sclk_q && ((sclk_i != cpol_i) != cpha_i)) begin
            rx_o = {rx_o[30:0], mosi_i};
        end else if (ss_i && sclk_i != sclk_q) begin
            if (!(cpha_i && first_r)) sh_r = {sh_r[30:0], 1'b0};
            first_r = 1'b0;
        end
        ss_q   = ss_i;
        sclk_q = sclk_i;
    end
endmodule : smsp_far

// ### verification/smsp_port_test.sv
// self-checking testbench for the spi master/slave port
`timescale 1ns/1ps
module smsp_port_test
    import smsp_pkg::*;
;
    typedef struct packed {logic [7:0] ctrl; logic [31:0] mtx, ptx, mrx, prx;} smsp_row_t;
    localparam smsp_row_t ROWS [7] = '{
        '{8'h30, 32'hC3, 32'h5A000000, 32'h5A, 32'hC3}, '{8'h71, 32'h81, 32'h7E000000, 32'h7E, 32'h81},
        '{8'hB2, 32'h3C, 32'h96000000, 32'h96, 32'h3C}, '{8'hF7, 32'h12345678, 32'h9ABCDEF0, 32'h9ABCDEF0, 32'h12345678},
        '{8'h3C, 32'hA5A5F00F, 32'h0FF05AA5, 32'h0FF05AA5, 32'hA5A5F00F},
        '{8'h20, 32'h66, 32'hFF000000, 32'h0, 32'h66}, '{8'h10, 32'h0, 32'h44000000, 32'h44, 32'h0}};
    localparam logic [7:0]  RA [6] = '{REG_CTRL, REG_DIV, REG_DELAY, REG_GAP, REG_STATUS, 8'h3C};
    localparam logic [31:0] RV [6] = '{32'h30, 32'h4, 32'h2, 32'h4, 32'h0, 32'h0};
    logic              clk_sys_i, srst_i, wr_r, rd_r, s_sclk_r, s_ss_r, s_mosi_r;
    logic [ADDR_W-1:0] addr_r;
    logic [DATA_W-1:0] wdata_r, rdata, prx, rv, ptx_r;
    logic [NUM_SS-1:0] ss, ss_seen;
    logic              sclk, mosi, mosi_oe, miso, s_miso, s_miso_oe, s_req, s_end, mosi_w, sclk_q;
    logic              seen = 1'b0;
    logic [1:0]        cfg;
    logic [31:0]       b;
    int                err_count, checked, lo, gap, pre, nreq, nend, nrise, n, k;
    // undriven mosi shows the inverse of the master's last bit
    assign mosi_w = mosi_oe ? mosi : ~mosi;
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end
    smsp_port i_smsp_port (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_r), .wdata_i(wdata_r),
        .wr_i(wr_r), .rd_i(rd_r), .rdata_o(rdata), .m_sclk_o(sclk), .m_mosi_o(mosi), .m_mosi_oe_o(mosi_oe),
        .m_miso_i(miso), .m_ss_o(ss), .s_sclk_i(s_sclk_r), .s_ss_i(s_ss_r), .s_mosi_i(s_mosi_r),
        .s_miso_o(s_miso), .s_miso_oe_o(s_miso_oe), .slv_req_o(s_req), .slv_end_o(s_end));
    smsp_far i_smsp_far (.sclk_i(sclk), .ss_i(|ss), .mosi_i(mosi_w), .cpol_i(cfg[1]), .cpha_i(cfg[0]),
        .tx_i(ptx_r), .miso_o(miso), .rx_o(prx));
    // ------------------------------------------------------------------
    // pin monitor: select gap, select-to-first-edge time, slave pulses
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        sclk_q <= sclk;
        if (s_req === 1'b1) nreq <= nreq + 1;
        if (s_end === 1'b1) nend <= nend + 1;
        if (ss === 4'h0) lo <= lo + 1;
        else begin
            lo <= 0;
            if (lo != 0) begin
                gap   <= lo;
                nrise <= nrise + 1;
                pre   <= 0;
                seen  <= 1'b0;
            end else if (sclk !== sclk_q) seen <= 1'b1;
            else if (!seen) pre <= pre + 1;
        end
    end
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic close_out();
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : close_out
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_r  <= a;
        wdata_r <= d;
        wr_r    <= 1'b1;
        @(posedge clk_sys_i);
        wr_r <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr_r <= a;
        rd_r   <= 1'b1;
        @(posedge clk_sys_i);
        rd_r <= 1'b0;
        @(negedge clk_sys_i);
        d = rdata;
    endtask : rreg
    task automatic wdone();
        rv = '0;
        for (n = 0; n < 300 && rv[ST_M_DONE] !== 1'b1; n++) begin
            rreg(REG_STATUS, rv);
            if (ss !== 4'h0) ss_seen = ss;
        end
        if (rv[ST_M_DONE] !== 1'b1) begin
            err_count++;
            close_out();
        end
    endtask : wdone
    // bench acts as the far master on the slave pins, mode with cpol 0 cpha 0, nb bits
    task automatic sx(input int nb, input logic [31:0] tx, output logic [31:0] rx);
        rx = '0;
        @(posedge clk_sys_i);
        s_ss_r <= 1'b1;
        repeat (12) @(posedge clk_sys_i); // leaves the client time to answer
        for (int i = nb - 1; i >= 0; i--) begin
            s_mosi_r <= tx[i];
            repeat (7) @(posedge clk_sys_i);
            @(negedge clk_sys_i);
            rx[i] = s_miso;
            @(posedge clk_sys_i);
            s_sclk_r <= 1'b1;
            repeat (8) @(posedge clk_sys_i);
            s_sclk_r <= 1'b0;
        end
        repeat (8) @(posedge clk_sys_i);
        s_ss_r <= 1'b0;
        repeat (12) @(posedge clk_sys_i); // idle time for the end notice
    endtask : sx
    initial begin
        {srst_i, wr_r, rd_r, s_sclk_r, s_ss_r, s_mosi_r} = 6'b100000;
        {addr_r, wdata_r, ptx_r, cfg} = '0;
        repeat (3) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rreg(RA[i], rv);
            cmp("reset value", RV[i], rv);
        end
        foreach (ROWS[i]) begin
            cfg     = ROWS[i].ctrl[1:0];
            ptx_r   = ROWS[i].ptx;
            ss_seen = '0;
            wreg(REG_CTRL, {24'h0, ROWS[i].ctrl});
            wreg(REG_MTX, ROWS[i].mtx);
            wreg(REG_STATUS, 32'h7F);
            @(negedge clk_sys_i);
            cmp("idle sclk", {31'h0, cfg[1]}, {31'h0, sclk});
            wreg(REG_CMD, 32'h1);
            wdone();
            rreg(REG_MRX, rv);
            cmp("master rx", ROWS[i].mrx, rv);
            cmp("select", 32'h1 << ROWS[i].ctrl[7:6], {28'h0, ss_seen});
            cmp("select dropped", 32'h0, {28'h0, ss});
            if (ROWS[i].ctrl[5]) cmp("far rx", ROWS[i].prx, ROWS[i].ctrl[2] ? prx : {24'h0, prx[7:0]});
        end
        wreg(REG_CTRL, 32'h28);
        wreg(REG_STATUS, 32'h7F);
        wreg(REG_CMD, 32'h1);
        repeat (4) @(posedge clk_sys_i);
        rreg(REG_STATUS, rv);
        cmp("refused", 32'h4, rv & 32'h7);
        wreg(REG_CTRL, 32'h30);
        wreg(REG_DELAY, 32'h14);
        wreg(REG_GAP, 32'h0A);
        k = nrise;
        wreg(REG_CMD, 32'h1);
        wreg(REG_CMD, 32'h1);
        for (n = 0; n < 1000 && nrise < k + 2; n++) @(posedge clk_sys_i);
        cmp("second start", k + 2, nrise);
        if (nrise < k + 2) close_out();
        wreg(REG_STATUS, 32'h7F);
        wdone();
        cmp("gap", 32'h1, {31'h0, gap >= 11});
        cmp("delay", 32'h1, {31'h0, pre >= 21});
        wreg(REG_STX, 32'hA5);
        wreg(REG_STATUS, 32'h7F);
        repeat (16) begin
            @(posedge clk_sys_i);
            s_sclk_r <= ~s_sclk_r;
            s_mosi_r <= ~s_mosi_r;
        end
        rreg(REG_SRX, rv);
        cmp("ignored", 32'h0, rv | 32'(nreq));
        sx(8, 32'h69, b);
        rreg(REG_SRX, rv);
        cmp("slave rx", 32'h69, rv);
        cmp("slave tx", 32'hA5, b);
        cmp("req end", 32'h00010001, {nreq[15:0], nend[15:0]});
        rreg(REG_STATUS, rv);
        cmp("slave status", 32'h38, rv & 32'h38);
        wreg(REG_CTRL, 32'h34);
        wreg(REG_STX, 32'h3CA5960F);
        sx(32, 32'h6996C33C, b);
        rreg(REG_SRX, rv);
        cmp("slave rx 32", 32'h6996C33C, rv);
        cmp("slave tx 32", 32'h3CA5960F, b);
        close_out();
    end
endmodule : smsp_port_test
